// File: hw/switch_cfg_pkg.sv
// constants and carriers for the switch source select decode block
package switch_cfg_pkg;
   // register offsets on the serial register port
   localparam logic [7:0] FAST_MODES_ADDR = 8'h00;
   localparam logic [7:0] AUX_MODES_ADDR  = 8'h01;
   localparam logic [7:0] RX_SET_ADDR     = 8'h10;
   localparam logic [7:0] PULSE_LO_ADDR   = 8'h11;
   localparam logic [7:0] PULSE_HI_ADDR   = 8'h12;
   // reset values
   localparam logic [7:0] FAST_MODES_RST  = 8'h40;
   localparam logic [7:0] AUX_MODES_RST   = 8'h40;
   localparam logic [7:0] RX_SET_RST      = 8'h01;
   localparam logic [7:0] PULSE_LO_RST    = 8'h00;
   localparam logic [7:0] PULSE_HI_RST    = 8'h00;
   // implemented bits, reserved bits read zero
   localparam logic [7:0] MODES_MASK      = 8'h7f;
   localparam logic [7:0] RX_SET_MASK     = 8'h01;
   // field positions
   localparam int         EN_BIT          = 6;
   localparam int         SM_HI           = 5;
   localparam int         SM_LO           = 4;
   localparam int         CH_HI           = 3;
   localparam int         CH_LO           = 0;
   localparam int         TERM_ON_BIT     = 0;
   // switching mode codes
   localparam logic [1:0] MODE_QUAD       = 2'h0;
   localparam logic [1:0] MODE_DUAL       = 2'h1;
   localparam logic [1:0] MODE_SINGLE     = 2'h2;
   localparam logic [1:0] MODE_ILLEGAL    = 2'h3;
   // termination pulse timing
   localparam int         CLK_HZ          = 20_000_000;
   localparam int         PULSE_MS        = 100;
   localparam int         PULSE_CYCLES    = PULSE_MS * (CLK_HZ / 1000);
   localparam int         PULSE_CNT_W     = 21;

   typedef struct packed
   {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_wr_s;

   typedef struct packed
   {
      logic       en;
      logic [7:0] addr;
   } reg_rd_s;

   // one 16-bit source vector per common auxiliary line
   typedef struct packed
   {
      logic [3:0][15:0] com_sel;
   } aux_route_s;
endpackage : switch_cfg_pkg

// File: hw/term_pulse_timer.sv
// one-shot timer that holds the termination pulse window open
`timescale 1ns/1ps
module term_pulse_timer #(
   parameter int PULSE_CYCLES = switch_cfg_pkg::PULSE_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic start,
   output logic      busy
);
   localparam logic [switch_cfg_pkg::PULSE_CNT_W-1:0] LOAD =
      switch_cfg_pkg::PULSE_CNT_W'(PULSE_CYCLES - 1);

   logic [switch_cfg_pkg::PULSE_CNT_W-1:0] cnt_r;
   logic [switch_cfg_pkg::PULSE_CNT_W-1:0] cnt_nxt;
   logic                                   busy_nxt;

   // a new start restarts the full window
   assign cnt_nxt  = start ? LOAD : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
   assign busy_nxt = start | (cnt_r != '0);

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_r <= '0;
         busy  <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         busy  <= busy_nxt;
      end
   end
endmodule : term_pulse_timer

// File: hw/switch_source_select_decode.sv
// register bank and path select decode for the crosspoint switch
// Contract
// - fast single mode routes one of sixteen channels, A0..D3 by code order.
// - auxiliary enable low opens every auxiliary path; high connects selection.
// - auxiliary mode 00 quad, 01 dual, 10 single.
// - writing 11 to auxiliary mode keeps the previous mode.
// - aux quad uses low two select bits, whole source to four outputs.
// - aux dual: X0nn gives A_n and C_n, X1nn gives B_n and D_n.
// - aux single maps all four select bits to one of sixteen lines.
// - termination bit low disconnects inputs; high connects, subject to pulsing.
// - sixteen-to-one fast mapping only when fast mode holds 10.
// - pulse-enabled channels lose termination for 100 ms after a fast-path source switch; aux writes do not pulse.
`timescale 1ns/1ps
module switch_source_select_decode #(
   parameter int PULSE_CYCLES = switch_cfg_pkg::PULSE_CYCLES
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst_b,
   input  switch_cfg_pkg::reg_wr_s          wr,
   input  switch_cfg_pkg::reg_rd_s          rd,
   output logic [7:0]                       rd_data,
   output logic [15:0]                      fast_sel,
   output switch_cfg_pkg::aux_route_s       aux_route,
   output logic [15:0]                      term_on
);
   ////////////////////////////////////////////////////////////////////////////////
   // functions
   function automatic logic [15:0] onehot16(input logic [3:0] idx);
      onehot16 = 16'h0001 << idx;
   endfunction : onehot16

   // illegal mode code leaves the stored mode alone
   function automatic logic [7:0] merge_modes(input logic [7:0] old_v,
                                              input logic [7:0] new_v);
      logic [1:0] sm;
      sm = new_v[switch_cfg_pkg::SM_HI:switch_cfg_pkg::SM_LO];
      if (sm == switch_cfg_pkg::MODE_ILLEGAL)
         sm = old_v[switch_cfg_pkg::SM_HI:switch_cfg_pkg::SM_LO];
      merge_modes = {1'b0, new_v[switch_cfg_pkg::EN_BIT], sm,
                     new_v[switch_cfg_pkg::CH_HI:switch_cfg_pkg::CH_LO]};
   endfunction : merge_modes

   // channel index A0..D3 to its pulse select bit
   function automatic int pulse_bit(input int chan);
      case (chan / 4)
         0:       pulse_bit = 4 + (chan % 4);
         1:       pulse_bit = chan % 4;
         2:       pulse_bit = 11 - (chan % 4);
         default: pulse_bit = 15 - (chan % 4);
      endcase
   endfunction : pulse_bit

   ////////////////////////////////////////////////////////////////////////////////
   // register bank
   logic [7:0]  fast_modes_r;
   logic [7:0]  aux_modes_r;
   logic [7:0]  rx_set_r;
   logic [15:0] pulse_r;
   logic [7:0]  fast_modes_nxt;
   logic [7:0]  aux_modes_nxt;
   logic [7:0]  rx_set_nxt;
   logic [15:0] pulse_nxt;
   logic        wr_fast;
   logic        wr_aux;
   logic        wr_rx;
   logic        wr_plo;
   logic        wr_phi;

   assign wr_fast        = wr.en && (wr.addr == switch_cfg_pkg::FAST_MODES_ADDR);
   assign wr_aux         = wr.en && (wr.addr == switch_cfg_pkg::AUX_MODES_ADDR);
   assign wr_rx          = wr.en && (wr.addr == switch_cfg_pkg::RX_SET_ADDR);
   assign wr_plo         = wr.en && (wr.addr == switch_cfg_pkg::PULSE_LO_ADDR);
   assign wr_phi         = wr.en && (wr.addr == switch_cfg_pkg::PULSE_HI_ADDR);
   assign fast_modes_nxt = wr_fast ? merge_modes(fast_modes_r, wr.data) : fast_modes_r;
   assign aux_modes_nxt  = wr_aux ? merge_modes(aux_modes_r, wr.data) : aux_modes_r;
   assign rx_set_nxt     = wr_rx ? (wr.data & switch_cfg_pkg::RX_SET_MASK) : rx_set_r;
   assign pulse_nxt      = {wr_phi ? wr.data : pulse_r[15:8],
                            wr_plo ? wr.data : pulse_r[7:0]};

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fast_modes_r <= switch_cfg_pkg::FAST_MODES_RST;
         aux_modes_r  <= switch_cfg_pkg::AUX_MODES_RST;
         rx_set_r     <= switch_cfg_pkg::RX_SET_RST;
         pulse_r      <= {switch_cfg_pkg::PULSE_HI_RST, switch_cfg_pkg::PULSE_LO_RST};
      end
      else
      begin
         fast_modes_r <= fast_modes_nxt;
         aux_modes_r  <= aux_modes_nxt;
         rx_set_r     <= rx_set_nxt;
         pulse_r      <= pulse_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read port, registered, unmapped reads zero
   logic [7:0] rd_mux;
   logic [7:0] rd_data_nxt;

   assign rd_mux =
      (rd.addr == switch_cfg_pkg::FAST_MODES_ADDR) ? fast_modes_r :
      (rd.addr == switch_cfg_pkg::AUX_MODES_ADDR)  ? aux_modes_r  :
      (rd.addr == switch_cfg_pkg::RX_SET_ADDR)     ? rx_set_r     :
      (rd.addr == switch_cfg_pkg::PULSE_LO_ADDR)   ? pulse_r[7:0] :
      (rd.addr == switch_cfg_pkg::PULSE_HI_ADDR)   ? pulse_r[15:8] : 8'h00;
   assign rd_data_nxt = rd.en ? rd_mux : rd_data;

   ////////////////////////////////////////////////////////////////////////////////
   // fast switch decode
   logic [1:0]  fast_sm;
   logic [3:0]  fast_ch;
   logic [15:0] fast_dec;
   logic        fast_switch;

   assign fast_sm     = fast_modes_r[switch_cfg_pkg::SM_HI:switch_cfg_pkg::SM_LO];
   assign fast_ch     = fast_modes_r[switch_cfg_pkg::CH_HI:switch_cfg_pkg::CH_LO];
   assign fast_dec    = (fast_sm == switch_cfg_pkg::MODE_SINGLE) ? onehot16(fast_ch)
                        : 16'h0000;
   // a changed mode or source counts as a source switch
   assign fast_switch = wr_fast && (fast_modes_nxt != fast_modes_r);

   ////////////////////////////////////////////////////////////////////////////////
   // auxiliary switch decode
   logic                    aux_en;
   logic [1:0]              low_speed_switch_mode;
   logic [3:0]              low_speed_source_select;
   switch_cfg_pkg::aux_route_s aux_dec;

   assign aux_en = aux_modes_r[switch_cfg_pkg::EN_BIT];
   assign low_speed_switch_mode = aux_modes_r[switch_cfg_pkg::SM_HI:switch_cfg_pkg::SM_LO];
   assign low_speed_source_select = aux_modes_r[switch_cfg_pkg::CH_HI:switch_cfg_pkg::CH_LO];

   genvar k;
   generate
      for (k = 0; k < 4; k++)
      begin : g_com
         localparam logic [1:0] LINE = 2'(k);
         localparam logic       HALF = (k >= 2);
         logic [15:0] quad_v;
         logic [15:0] dual_v;
         logic [15:0] mode_v;
         assign quad_v = onehot16({low_speed_source_select[1:0], LINE});
         assign dual_v = onehot16({HALF, low_speed_source_select[2], low_speed_source_select[1:0]});
         assign mode_v = (low_speed_switch_mode == switch_cfg_pkg::MODE_QUAD)   ? quad_v :
                         (low_speed_switch_mode == switch_cfg_pkg::MODE_DUAL)   ? dual_v :
                         (low_speed_switch_mode == switch_cfg_pkg::MODE_SINGLE) ? onehot16(low_speed_source_select)
                         : 16'h0000;
         assign aux_dec.com_sel[k] = aux_en ? mode_v : 16'h0000;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // input termination with pulse-off window
   logic        pulse_busy;
   logic [15:0] pulse_chan;
   logic [15:0] term_nxt;

   term_pulse_timer #(
      .PULSE_CYCLES (PULSE_CYCLES)
   ) u_pulse (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .start    (fast_switch),
      .busy     (pulse_busy)
   );

   genvar c;
   generate
      for (c = 0; c < 16; c++)
      begin : g_term
         assign pulse_chan[c] = pulse_r[pulse_bit(c)];
         assign term_nxt[c]   = rx_set_r[switch_cfg_pkg::TERM_ON_BIT]
                                && !(pulse_chan[c] && pulse_busy);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // output flops, one cycle behind the registers
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_data   <= 8'h00;
         fast_sel  <= 16'h0000;
         aux_route <= '0;
         term_on   <= 16'h0000;
      end
      else
      begin
         rd_data   <= rd_data_nxt;
         fast_sel  <= fast_dec;
         aux_route <= aux_dec;
         term_on   <= term_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_fast_single;
      (fast_sm == switch_cfg_pkg::MODE_SINGLE) |=> fast_sel[$past(fast_ch)] && $onehot(fast_sel);
   endproperty
   a_fast_single: assert property (p_fast_single) else $error("fast single route wrong");

   property p_fast_other;
      (fast_sm != switch_cfg_pkg::MODE_SINGLE) |=> (fast_sel == 16'h0000);
   endproperty
   a_fast_other: assert property (p_fast_other) else $error("fast route outside single");

   property p_aux_off;
      !aux_en |=> (aux_route == '0);
   endproperty
   a_aux_off: assert property (p_aux_off) else $error("aux path open while off");

   property p_aux_illegal;
      (wr_aux && (wr.data[switch_cfg_pkg::SM_HI:switch_cfg_pkg::SM_LO]
                  == switch_cfg_pkg::MODE_ILLEGAL)) |=> (low_speed_switch_mode == $past(low_speed_switch_mode));
   endproperty
   a_aux_illegal: assert property (p_aux_illegal) else $error("illegal aux mode stored");

   property p_aux_quad;
      (aux_en && low_speed_switch_mode == switch_cfg_pkg::MODE_QUAD)
         |=> (aux_route.com_sel[2] == onehot16({$past(low_speed_source_select[1:0]), 2'h2}));
   endproperty
   a_aux_quad: assert property (p_aux_quad) else $error("aux quad route wrong");

   property p_aux_dual;
      (aux_en && low_speed_switch_mode == switch_cfg_pkg::MODE_DUAL)
         |=> (aux_route.com_sel[3] == onehot16({1'b1, $past(low_speed_source_select[2:0])}));
   endproperty
   a_aux_dual: assert property (p_aux_dual) else $error("aux dual route wrong");

   property p_aux_single;
      (aux_en && low_speed_switch_mode == switch_cfg_pkg::MODE_SINGLE)
         |=> aux_route.com_sel[0][$past(low_speed_source_select)] && $onehot(aux_route.com_sel[0]);
   endproperty
   a_aux_single: assert property (p_aux_single) else $error("aux single route wrong");

   property p_term_off;
      !rx_set_r[switch_cfg_pkg::TERM_ON_BIT] |=> (term_on == 16'h0000);
   endproperty
   a_term_off: assert property (p_term_off) else $error("termination not off");

   property p_pulse;
      fast_switch ##1 rx_set_r[switch_cfg_pkg::TERM_ON_BIT]
         |=> ((term_on & $past(pulse_chan)) == 16'h0000);
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulsed termination not off");

   property p_hold;
      (!wr.en) [*2] |=> $stable(fast_sel) && $stable(aux_route);
   endproperty
   a_hold: assert property (p_hold) else $error("selection changed without write");

   property p_onehot;
      $onehot0(fast_sel) && $onehot0(aux_route.com_sel[0]) && $onehot0(aux_route.com_sel[1])
         && $onehot0(aux_route.com_sel[2]) && $onehot0(aux_route.com_sel[3]);
   endproperty
   a_onehot: assert property (p_onehot) else $error("select not one-hot");

   c_fast_single: cover property (fast_sm == switch_cfg_pkg::MODE_SINGLE ##1 fast_sel != 0);
   c_aux_dual:    cover property (aux_en && low_speed_switch_mode == switch_cfg_pkg::MODE_DUAL);
   c_pulse:       cover property (fast_switch ##1 pulse_busy && (pulse_chan != 16'h0000));
   c_illegal:     cover property (wr_aux && wr.data[switch_cfg_pkg::SM_HI:switch_cfg_pkg::SM_LO]
                                  == switch_cfg_pkg::MODE_ILLEGAL);
endmodule : switch_source_select_decode

// File: verif/switch_host_model.sv
// host model that writes and reads the switch configuration registers
`timescale 1ns/1ps
module switch_host_model (
   input  wire logic               core_clk,
   output switch_cfg_pkg::reg_wr_s wr,
   output switch_cfg_pkg::reg_rd_s rd,
   input  wire logic [7:0]         rd_data
);
   initial
   begin
      wr = '0;
      rd = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // called at a falling edge; an idle cycle follows each strobe
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      wr = '{en: 1'b1, addr: addr, data: data};
      @(negedge core_clk);
      wr.en = 1'b0;
      @(negedge core_clk);
   endtask : write_reg

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      rd = '{en: 1'b1, addr: addr};
      @(negedge core_clk);
      rd.en = 1'b0;
      data  = rd_data;
      @(negedge core_clk);
   endtask : read_reg
endmodule : switch_host_model

// File: verif/switch_source_select_decode_test.sv
// self-checking bench for the switch source select decode block
`timescale 1ns/1ps
module switch_source_select_decode_test;
   localparam int              PC = 8;
   logic                       core_clk;
   logic                       rst_b;
   switch_cfg_pkg::reg_wr_s    wr;
   switch_cfg_pkg::reg_rd_s    rd;
   logic [7:0]                 rd_data;
   logic [15:0]                fast_sel;
   switch_cfg_pkg::aux_route_s aux_route;
   logic [15:0]                term_on;
   int                         err_count;
   int                         samples_checked;
   logic [7:0]                 rv;

   switch_source_select_decode #(.PULSE_CYCLES(PC)) DUT (
      .core_clk(core_clk), .rst_b(rst_b), .wr(wr), .rd(rd), .rd_data(rd_data),
      .fast_sel(fast_sel), .aux_route(aux_route), .term_on(term_on));

   switch_host_model host (
      .core_clk(core_clk), .wr(wr), .rd(rd), .rd_data(rd_data));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic chk_rd(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      host.read_reg(addr, d);
      check(d, exp, "read data");
   endtask : chk_rd

   // one-hot source index per common line, bit = line*16+source
   function automatic logic [63:0] aux_exp(input logic [1:0] m, input logic [3:0] c,
                                           input logic en);
      logic [63:0] r;
      int          s;
      r = '0;
      for (int k = 0; k < 4; k++)
      begin
         if (m == switch_cfg_pkg::MODE_QUAD)
            s = c[1:0] * 4 + k;
         else if (m == switch_cfg_pkg::MODE_DUAL)
            s = (c[2] ? 4 : 0) + (k >= 2 ? 8 : 0) + c[1:0];
         else
            s = c;
         if (en)
            r[k * 16 + s] = 1'b1;
      end
      return r;
   endfunction : aux_exp

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial
   begin
      #(50 * 3000);
      err_count++;
      $display("watchdog expired");
      complete_run();
   end

   initial
   begin
      rst_b           = 1'b0;
      err_count       = 0;
      samples_checked = 0;
      repeat (5) @(negedge core_clk);
      rst_b = 1'b1;
      @(negedge core_clk);
      check(fast_sel, 64'h0, "reset fast");
      check(aux_route, aux_exp(switch_cfg_pkg::MODE_QUAD, 4'h0, 1'b1), "reset aux");
      check(term_on, 64'hffff, "reset term");
      chk_rd(switch_cfg_pkg::FAST_MODES_ADDR, switch_cfg_pkg::FAST_MODES_RST);
      chk_rd(switch_cfg_pkg::AUX_MODES_ADDR, switch_cfg_pkg::AUX_MODES_RST);
      chk_rd(switch_cfg_pkg::RX_SET_ADDR, switch_cfg_pkg::RX_SET_RST);
      chk_rd(switch_cfg_pkg::PULSE_LO_ADDR, switch_cfg_pkg::PULSE_LO_RST);
      chk_rd(switch_cfg_pkg::PULSE_HI_ADDR, switch_cfg_pkg::PULSE_HI_RST);
      chk_rd(8'h05, 8'h00);
      $display("test reset done");
      for (int c = 0; c < 16; c++)
      begin
         host.write_reg(switch_cfg_pkg::FAST_MODES_ADDR, {4'h2, 4'(c)});
         check(fast_sel, 64'h1 << c, "fast single");
      end
      host.write_reg(switch_cfg_pkg::FAST_MODES_ADDR, 8'h05);
      check(fast_sel, 64'h0, "fast quad");
      host.write_reg(switch_cfg_pkg::FAST_MODES_ADDR, 8'h15);
      check(fast_sel, 64'h0, "fast dual");
      host.write_reg(switch_cfg_pkg::FAST_MODES_ADDR, 8'h25);
      host.write_reg(switch_cfg_pkg::FAST_MODES_ADDR, 8'h35);
      check(fast_sel, 64'h20, "fast illegal mode");
      chk_rd(switch_cfg_pkg::FAST_MODES_ADDR, 8'h25);
      $display("test fast done");
      for (int m = 0; m < 3; m++)
      begin
         for (int c = 0; c < 16; c++)
         begin
            host.write_reg(switch_cfg_pkg::AUX_MODES_ADDR, {2'b01, 2'(m), 4'(c)});
            check(aux_route, aux_exp(2'(m), 4'(c), 1'b1), "aux mode");
         end
      end
      host.write_reg(switch_cfg_pkg::AUX_MODES_ADDR, 8'h73);
      check(aux_route, aux_exp(switch_cfg_pkg::MODE_SINGLE, 4'h3, 1'b1), "aux kept");
      chk_rd(switch_cfg_pkg::AUX_MODES_ADDR, 8'h63);
      host.write_reg(switch_cfg_pkg::AUX_MODES_ADDR, 8'h01);
      check(aux_route, 64'h0, "aux off");
      host.write_reg(switch_cfg_pkg::AUX_MODES_ADDR, 8'h55);
      check(aux_route, aux_exp(switch_cfg_pkg::MODE_DUAL, 4'h5, 1'b1), "aux on");
      $display("test aux done");
      host.write_reg(switch_cfg_pkg::PULSE_LO_ADDR, 8'h0f);
      host.write_reg(switch_cfg_pkg::PULSE_HI_ADDR, 8'h01);
      host.write_reg(switch_cfg_pkg::AUX_MODES_ADDR, 8'h42);
      check(term_on, 64'hffff, "no pulse on aux write");
      host.write_reg(switch_cfg_pkg::FAST_MODES_ADDR, 8'h2a);
      check(term_on, 64'hf70f, "pulse start");
      repeat (PC - 1) @(negedge core_clk);
      check(term_on, 64'hf70f, "pulse held");
      repeat (1) @(negedge core_clk);
      check(term_on, 64'hffff, "pulse end");
      host.write_reg(switch_cfg_pkg::RX_SET_ADDR, 8'hfe);
      check(term_on, 64'h0, "termination off");
      chk_rd(switch_cfg_pkg::RX_SET_ADDR, 8'h00);
      host.write_reg(switch_cfg_pkg::RX_SET_ADDR, 8'h01);
      check(term_on, 64'hffff, "termination on");
      $display("test termination done");
      complete_run();
   end
endmodule : switch_source_select_decode_test
